/* File: bench/mbp_props.sv */
// Link checker for the bridge serial port, fed the interface wires.
// Assumes one core clock domain and a host that makes sclk itself.
`timescale 1ns/1ps
`default_nettype none
module mbp_props (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_n_i,    // Sync reset, low
  input wire logic sclk,       // Serial clock
  input wire logic cs_n,       // Select, low
  input wire logic mosi,       // Host data
  input wire logic miso        // Device data
);
  // --------------------------------
  // Frame bookkeeping
  // --------------------------------
  logic [5:0] n_rise; // Rises seen in this frame
  logic       sclk_q; // Last sclk level
  always_ff @(posedge core_clk_i) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || cs_n) begin
      n_rise <= 6'h00;
    end else if (sclk && !sclk_q) begin
      n_rise <= n_rise + 6'h01;
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_high_half;
    sclk [*4] ##1 $fell(sclk);
  endsequence
  sequence s_low_half;
    !sclk [*4] ##1 $rose(sclk);
  endsequence
  AST_IDLE_LOW: assert property (cs_n |-> !sclk)
    else $error("sclk moved outside a frame");
  AST_HIGH_HALF: assert property ($rose(sclk) |=> s_high_half)
    else $error("sclk high phase not five cycles");
  AST_LOW_HALF: assert property ($fell(sclk) && n_rise != 6'h20 |=> s_low_half)
    else $error("sclk low phase not five cycles");
  AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
    else $error("mosi changed while sclk high");
  AST_MISO_HOLD: assert property ($rose(sclk) |-> $stable(miso))
    else $error("miso changed at sclk rise");
  AST_START: assert property ($fell(cs_n) |-> !sclk [*2] ##[1:8] $rose(sclk))
    else $error("first sclk rise late or early");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> n_rise == 6'h20)
    else $error("frame not 32 clocks");
  AST_END: assert property ($fell(sclk) && n_rise == 6'h20 |-> ##[0:8] $rose(cs_n))
    else $error("select not released after frame");
  AST_GAP: assert property ($rose(cs_n) |-> cs_n [*3])
    else $error("select gap too short");
endmodule : mbp_props
`default_nettype wire

/* File: bench/tb.sv */
// Bench joining host and device ends; drives both user sides.
// Assumes a 125 MHz core clock and the register map of mbp_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mbp_pkg::*;
  localparam int D = 4; // Short FIFO keeps the fill test brief
  logic core_clk_i, rst_n_i, req_i, write_i, busy, done_o, rxd, dbg, txd, pld;
  logic iv, ir, ov, own;
  logic [14:0] addr_i;
  logic [15:0] wdata_i, rdata_o, mi;
  logic [7:0]  p0, p1, ib, ob, v;
  logic [3:0]  irq;
  logic [1:0]  mode;
  logic [31:0] mo;
  int          n_tests, n_mismatch, k;
  mbp_link_if link();
  mbp_host i_mbp_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link(link),
    .req_i(req_i), .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .busy_o(busy), .done_o(done_o), .rdata_o(rdata_o));
  mbp_device #(.DEPTH(D)) i_mbp_device (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .link(link), .mcu_port_zero_inputs_o(p0), .mcu_port_one_outputs_i(p1),
    .mcu_rxd_o(rxd), .mcu_debug_o(dbg), .mcu_irq_inputs_o(irq), .mcu_mode_o(mode),
    .mcu_txd_i(txd), .program_load_done_i(pld), .mcu_input_bus_o(ib),
    .mcu_in_valid_o(iv), .mcu_in_ready_i(ir), .mcu_to_host_byte_i(ob),
    .mcu_out_valid_i(ov), .control_owner_select_o(own));
  mbp_props i_mbp_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  // --------------------------------
  // Wire monitor and tasks
  // --------------------------------
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      mo <= {mo[30:0], link.mosi};
      mi <= {mi[14:0], link.miso};
    end
  end
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [14:0] a, input logic [15:0] d);
    int i;
    @(posedge core_clk_i);
    #1;
    req_i = 1'b1;
    write_i = w;
    addr_i = a;
    wdata_i = d;
    @(posedge core_clk_i);
    #1;
    req_i = 1'b0;
    chk(busy, 1'b1);
    i = 0;
    while (done_o !== 1'b1 && i < 600) begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    if (i == 600) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, done_o, 1'b1);
      summarize();
    end
    chk(busy, 1'b0);
    repeat (3) @(posedge core_clk_i); // Select gap before the next frame
    #1;
  endtask : xfer
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    xfer(CMD_WRITE, a, d);
    chk(mo, {CMD_WRITE, a, d});
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [15:0] e);
    xfer(~CMD_WRITE, a, 16'h0000);
    chk(rdata_o, e);
    chk(mi, e);
    chk(mo[31:16], {~CMD_WRITE, a});
  endtask : rd
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {rst_n_i, req_i, write_i, addr_i, wdata_i, ir, ov, ob} = '0;
    p1 = 8'hA5;
    txd = 1'b1;
    pld = 1'b1;
    n_tests = 0;
    n_mismatch = 0;
    repeat (4) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    rd(ADDR_PORT_IN, 16'h0000);
    rd(ADDR_PIN_CTRL, 16'h0000);
    rd(ADDR_OWNER, 16'h0000);
    rd(ADDR_STATUS, 16'h00C1);
    wr(ADDR_PORT_IN, 16'hFF3C);
    chk(p0, 8'h3C);
    rd(ADDR_PORT_IN, 16'h003C);
    wr(ADDR_PORT_OUT, 16'h0011);
    rd(ADDR_PORT_OUT, 16'h00A5);
    for (int m = 0; m < 4; m++) begin
      v = (m[0] ? 8'h54 : 8'hA8) | 8'(m);
      wr(ADDR_PIN_CTRL, {8'hFF, v});
      chk({rxd, dbg, irq, mode}, v);
      rd(ADDR_PIN_CTRL, {8'h00, v});
    end
    txd = 1'b0;
    pld = 1'b0;
    rd(ADDR_STATUS, 16'h0001);
    ob = 8'h5A;
    ov = 1'b1;
    @(posedge core_clk_i);
    #1;
    ov = 1'b0;
    rd(ADDR_STATUS, 16'h0009);
    rd(ADDR_FROM_MCU, 16'h005A);
    rd(ADDR_STATUS, 16'h0001);
    // Receiver stalls; FIFO plus two skid slots fill, the extra byte drops
    for (k = 0; k < D + 2; k++) begin
      if (k == D + 1) rd(ADDR_STATUS, 16'h0004);
      wr(ADDR_TO_MCU, 16'hFF30 + 16'(k));
    end
    rd(ADDR_STATUS, 16'h0006);
    // Deliberate write while full: the device must drop it
    wr(ADDR_TO_MCU, 16'h00EE);
    chk({iv, ib}, 9'h130);
    k = 0;
    for (int c = 0; c < 200; c++) begin
      @(posedge core_clk_i);
      #1;
      ir = c[0];
      // Settled values here are what the next edge takes
      if (iv === 1'b1 && ir === 1'b1) begin
        chk(ib, 8'h30 + k);
        k++;
      end
    end
    chk(k, D + 2);
    rd(ADDR_STATUS, 16'h0001);
    wr(ADDR_OWNER, 16'h0001);
    chk(own, 1'b1);
    rd(ADDR_OWNER, 16'h0001);
    summarize();
  end
endmodule : tb
`default_nettype wire

/* File: hw/mbp_device.sv */
// Bridge device end: serial slave, register map, input FIFO toward the MCU.
// Assumes link pins are asynchronous to core_clk_i and are synchronised here.
//
// Notes on behaviour
// - Port-in register drives MCU port zero.
// - Port-out register reads MCU port one.
// - Control bit 7 drives MCU receive pin.
// - Control bit 6 selects debug mode.
// - Control bits 5..2 drive MCU interrupts.
// - Mode field selects reset or load source.
// - Status bit 6 shows program load done.
// - Status bit 7 shows MCU transmit pin.
// - Status bit 3 shows byte from MCU.
// - Status bit 2 shows byte awaiting transfer.
// - Status bit 1 shows input FIFO full.
// - Host stops writing while FIFO full; a write made while full is dropped.
// - Status bit 0 shows input FIFO empty.
// - Written byte goes onto MCU input bus.
// - Read-back register returns MCU output byte.
// - Owner bit picks host or MCU control.
// - Frame opens with command bit, 15-bit address.
// - Read returns 16 bits MSB first.
// - Write sends 16 data bits MSB first.
// - Host sets data then pulses clock.
`timescale 1ns/1ps
`default_nettype none
module mbp_device
  import mbp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       core_clk_i,          // Core clock
  input  wire logic       rst_n_i,             // Synchronous reset, low
  mbp_link_if.device      link,                // Serial link
  output logic [7:0]      mcu_port_zero_inputs_o, // MCU port zero
  input  wire logic [7:0] mcu_port_one_outputs_i, // MCU port one
  output logic            mcu_rxd_o,           // MCU receive pin
  output logic            mcu_debug_o,         // Debug mode enable
  output logic [3:0]      mcu_irq_inputs_o,    // MCU interrupts
  output logic [1:0]      mcu_mode_o,          // Load mode
  input  wire logic       mcu_txd_i,           // MCU transmit pin
  input  wire logic       program_load_done_i, // MCU running
  output logic [7:0]      mcu_input_bus_o,     // Byte into MCU
  output logic            mcu_in_valid_o,      // Byte offered
  input  wire logic       mcu_in_ready_i,      // MCU takes byte
  input  wire logic [7:0] mcu_to_host_byte_i,  // Byte from MCU
  input  wire logic       mcu_out_valid_i,     // Byte from MCU strobe
  output logic            control_owner_select_o // 1: MCU owns transceiver
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Link synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] sclk_s, cs_s, mosi_s;
  logic       sclk_d;
  always_ff @(posedge core_clk_i) begin
    sclk_s <= {sclk_s[0], link.sclk};
    cs_s   <= {cs_s[0], link.cs_n};
    mosi_s <= {mosi_s[0], link.mosi};
    sclk_d <= sclk_s[1];
  end
  wire rise = sclk_s[1] & ~sclk_d;
  wire fall = ~sclk_s[1] & sclk_d;
  wire sel  = ~cs_s[1];

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  logic [5:0]  bit_cnt;
  logic [15:0] cmd_sh, dat_sh, rd_sh;
  logic        wr_stb;
  logic [15:0] rd_word;
  always_ff @(posedge core_clk_i) begin
    wr_stb <= 1'b0;
    if (!rst_n_i || !sel) begin
      bit_cnt <= '0;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 6'd1;
      if (bit_cnt < 6'(CMD_BITS)) begin
        cmd_sh <= {cmd_sh[14:0], mosi_s[1]};
      end else begin
        dat_sh <= {dat_sh[14:0], mosi_s[1]};
        if (bit_cnt == 6'(FRAME_BITS - 1) && cmd_sh[15] == CMD_WRITE) begin
          wr_stb <= 1'b1;
        end
      end
    end
  end

  // MSB presented once the command phase ends, shifted on falling edges
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rd_sh <= '0;
    end else if (fall && bit_cnt == 6'(CMD_BITS)) begin
      rd_sh <= rd_word;
    end else if (fall && bit_cnt > 6'(CMD_BITS)) begin
      rd_sh <= {rd_sh[14:0], 1'b0};
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) link.miso <= 1'b0;
    else link.miso <= rd_sh[15];
  end

  // ----------------------------------------------------------------
  // Input FIFO toward the MCU, with a two-entry skid stage at the output
  // ----------------------------------------------------------------
  logic [7:0]  mem [DEPTH];
  logic [AW:0] cnt;
  logic [AW-1:0] wp, rp;
  wire push = wr_stb && cmd_sh[14:0] == ADDR_TO_MCU && cnt != (AW+1)'(DEPTH);
  logic [7:0] sk [2];
  logic [1:0] sk_n;
  wire pop  = cnt != '0 && sk_n != 2'd2;
  wire take = mcu_in_valid_o && mcu_in_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        mem[wp] <= dat_sh[7:0];
        wp <= wp + 1'b1;
      end
      if (pop) rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Skid keeps a stalled MCU from losing a byte already popped
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sk_n <= '0;
    end else begin
      if (take) sk[0] <= sk[1];
      if (pop) sk[(take ? sk_n - 2'd1 : sk_n) == 2'd0 ? 0 : 1] <= mem[rp];
      sk_n <= sk_n + 2'(pop) - 2'(take);
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mcu_input_bus_o <= '0;
      mcu_in_valid_o  <= 1'b0;
    end else begin
      mcu_in_valid_o  <= (sk_n - 2'(take)) != 2'd0 || pop;
      mcu_input_bus_o <= (take ? (sk_n == 2'd2 ? sk[1] : mem[rp]) : (sk_n != 2'd0 ? sk[0] : mem[rp]));
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pin_ctrl;
  logic [7:0] from_mcu;
  logic       rd_req;
  logic [1:0] txd_s, done_s;
  always_ff @(posedge core_clk_i) begin
    txd_s  <= {txd_s[0], mcu_txd_i};
    done_s <= {done_s[0], program_load_done_i};
  end
  wire do_wr = wr_stb;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mcu_port_zero_inputs_o <= PORT_IN_RST;
      pin_ctrl               <= PIN_CTRL_RST;
      control_owner_select_o <= OWNER_RST;
    end else if (do_wr) begin
      case (cmd_sh[14:0])
        ADDR_PORT_IN:  mcu_port_zero_inputs_o <= dat_sh[7:0];
        ADDR_PIN_CTRL: pin_ctrl <= dat_sh[7:0];
        ADDR_OWNER:    control_owner_select_o <= dat_sh[0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mcu_rxd_o        <= 1'b0;
      mcu_debug_o      <= 1'b0;
      mcu_irq_inputs_o <= '0;
      mcu_mode_o       <= MBP_MODE_RESET;
    end else begin
      mcu_rxd_o        <= pin_ctrl[CTRL_RXD_BIT];
      mcu_debug_o      <= pin_ctrl[CTRL_DEBUG_BIT];
      mcu_irq_inputs_o <= pin_ctrl[CTRL_IRQ_LSB +: 4];
      mcu_mode_o       <= pin_ctrl[CTRL_MODE_LSB +: 2];
    end
  end
  // Read-back flag: new MCU byte sets, a host read of the register clears; set wins
  wire rd_done = rise && sel && bit_cnt == 6'(FRAME_BITS - 1) && !cmd_sh[15]
                 && cmd_sh[14:0] == ADDR_FROM_MCU;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      from_mcu <= '0;
      rd_req   <= 1'b0;
    end else if (mcu_out_valid_i) begin
      from_mcu <= mcu_to_host_byte_i;
      rd_req   <= 1'b1;
    end else if (rd_done) begin
      rd_req   <= 1'b0;
    end
  end

  logic [7:0] status;
  always_comb begin
    status = '0;
    status[ST_TXD_BIT]   = txd_s[1];
    status[ST_DONE_BIT]  = done_s[1];
    status[ST_RDREQ_BIT] = rd_req;
    status[ST_WRREQ_BIT] = cnt != '0 || sk_n != '0;
    status[ST_FULL_BIT]  = cnt == (AW+1)'(DEPTH);
    status[ST_EMPTY_BIT] = cnt == '0;
  end
  always_comb begin
    rd_word = '0;
    case (cmd_sh[14:0])
      ADDR_PORT_IN:  rd_word[7:0] = mcu_port_zero_inputs_o;
      ADDR_PORT_OUT: rd_word[7:0] = mcu_port_one_outputs_i;
      ADDR_PIN_CTRL: rd_word[7:0] = pin_ctrl;
      ADDR_STATUS:   rd_word[7:0] = status;
      ADDR_FROM_MCU: rd_word[7:0] = from_mcu;
      ADDR_OWNER:    rd_word[0]   = control_owner_select_o;
      default:       rd_word = '0;
    endcase
  end
endmodule : mbp_device
`default_nettype wire

/* File: hw/mbp_host.sv */
// Host end: serial master that runs one 32-bit frame per request.
// Assumes the user waits for done_o before the next request.
`timescale 1ns/1ps
`default_nettype none
module mbp_host
  import mbp_pkg::*;
(
  input  wire logic        core_clk_i,  // Core clock
  input  wire logic        rst_n_i,     // Synchronous reset, low
  mbp_link_if.host         link,        // Serial link
  input  wire logic        req_i,       // Start a frame
  input  wire logic        write_i,     // 1 write, 0 read
  input  wire logic [14:0] addr_i,      // Register address
  input  wire logic [15:0] wdata_i,     // Write data
  output logic             busy_o,      // Frame in progress
  output logic             done_o,      // One-cycle end pulse
  output logic [15:0]      rdata_o      // Read data
);
  typedef enum logic [1:0] {
    MBP_H_IDLE = 2'b00,
    MBP_H_LOW  = 2'b01,
    MBP_H_HIGH = 2'b10
  } mbp_hstate_t;
  mbp_hstate_t st;
  logic [31:0] sh;
  logic [15:0] rx;
  logic [5:0]  nb;
  logic [2:0]  dv;
  logic [1:0]  miso_s;
  // Divider: one enable every half clock period
  wire tick = dv == 3'(SCLK_HALF_CYC - 1);
  always_ff @(posedge core_clk_i) begin
    miso_s <= {miso_s[0], link.miso};
  end
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || st == MBP_H_IDLE || tick) dv <= '0;
    else dv <= dv + 3'd1;
  end
  always_ff @(posedge core_clk_i) begin
    done_o <= 1'b0;
    if (!rst_n_i) begin
      st <= MBP_H_IDLE;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
      busy_o <= 1'b0;
      rdata_o <= '0;
      nb <= '0;
    end else begin
      case (st)
        MBP_H_IDLE: if (req_i) begin
          sh <= {(write_i ? CMD_WRITE : ~CMD_WRITE), addr_i, wdata_i};
          link.cs_n <= 1'b0;
          link.mosi <= write_i ? CMD_WRITE : ~CMD_WRITE;
          busy_o <= 1'b1;
          nb <= '0;
          st <= MBP_H_LOW;
        end
        MBP_H_LOW: if (tick) begin
          link.sclk <= 1'b1;
          st <= MBP_H_HIGH;
        end
        // Sample at the fall: device answer plus both synchronisers outlast half a period
        MBP_H_HIGH: if (tick) begin
          link.sclk <= 1'b0;
          if (nb >= 6'(CMD_BITS)) rx <= {rx[14:0], miso_s[1]};
          if (nb == 6'(FRAME_BITS - 1)) begin
            link.cs_n <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            rdata_o <= {rx[14:0], miso_s[1]};
            st <= MBP_H_IDLE;
          end else begin
            nb <= nb + 6'd1;
            sh <= {sh[30:0], 1'b0};
            link.mosi <= sh[30];
            st <= MBP_H_LOW;
          end
        end
        default: st <= MBP_H_IDLE;
      endcase
    end
  end
endmodule : mbp_host
`default_nettype wire

/* File: hw/mbp_link_if.sv */
// Four-wire serial link between host master and bridge device.
// Assumes the bench connects both modports; no tri-state is needed.
`timescale 1ns/1ps
`default_nettype none
interface mbp_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso);
endinterface : mbp_link_if
`default_nettype wire

/* File: hw/mbp_pkg.sv */
// Shared constants for the MCU bridge serial port: register map, fields, timing.
// Assumes both ends are clocked by one 125 MHz core clock.
package mbp_pkg;
  localparam logic [14:0] ADDR_PORT_IN   = 15'h0000;
  localparam logic [14:0] ADDR_PORT_OUT  = 15'h0001;
  localparam logic [14:0] ADDR_PIN_CTRL  = 15'h0002;
  localparam logic [14:0] ADDR_STATUS    = 15'h0003;
  localparam logic [14:0] ADDR_TO_MCU    = 15'h0004;
  localparam logic [14:0] ADDR_FROM_MCU  = 15'h0005;
  localparam logic [14:0] ADDR_OWNER     = 15'h0006;
  localparam int          CTRL_RXD_BIT   = 7;
  localparam int          CTRL_DEBUG_BIT = 6;
  localparam int          CTRL_IRQ_LSB   = 2;
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          ST_TXD_BIT     = 7;
  localparam int          ST_DONE_BIT    = 6;
  localparam int          ST_RDREQ_BIT   = 3;
  localparam int          ST_WRREQ_BIT   = 2;
  localparam int          ST_FULL_BIT    = 1;
  localparam int          ST_EMPTY_BIT   = 0;
  localparam logic [7:0]  PORT_IN_RST    = 8'h00;
  localparam logic [7:0]  PIN_CTRL_RST   = 8'h00;
  localparam logic        OWNER_RST      = 1'b0;
  localparam int          FIFO_DEPTH     = 32;
  localparam int          FRAME_BITS     = 32;
  localparam int          CMD_BITS       = 16;
  localparam logic        CMD_WRITE      = 1'b1;
  localparam int          SCLK_HALF_CYC  = 5;
  typedef enum logic [1:0] {
    MBP_MODE_RESET = 2'b00,
    MBP_MODE_BOTH  = 2'b01,
    MBP_MODE_SRAM  = 2'b10,
    MBP_MODE_EEPROM= 2'b11
  } mbp_mode_t;
endpackage : mbp_pkg
